// ==== logic/csit_pkg.sv ====
/*
  Constants, register map and carrier types of the CSI transmit control block.
  Assumes registers are reached over AHB-Lite, one 8-bit register per aligned word.
*/
package csit_pkg;

  localparam int CSIT_NREG = 56;
  localparam int CSIT_NTIM = 9;
  localparam int CSIT_NLANE = 5;
  localparam int CSIT_ADDR_TOP = 18;

  // Register positions in the storage array
  localparam int R_MAIN = 0, R_TSEL = 1, R_MISC = 2, R_LPRET = 3, R_PWR = 4, R_ULPX = 5;
  localparam int R_WKUP = 6, R_FMAXH = 7, R_FMAXL = 8, R_VC = 9, R_DT = 10;
  localparam int R_HZH = 11, R_HZL = 12, R_HTH = 13, R_HTL = 14, R_CZH = 15, R_CZL = 16;
  localparam int R_CPMAX = 17, R_CPMIN = 18, R_CPOH = 19, R_CPOL = 20, R_CTH = 21;
  localparam int R_CTL = 22, R_LXH = 23, R_LXL = 24, R_HPMIN = 25, R_HPMAX = 26;
  localparam int R_HEH = 27, R_HEL = 28, R_UHZ = 29, R_UHT = 30, R_UCZ = 31, R_UCP = 32;
  localparam int R_UCPO = 33, R_UCT = 34, R_ULX = 35, R_UHP = 36, R_UHE = 37, R_PKT = 38;
  localparam int R_PER = 39, R_GPIO0 = 40, R_GPIO1 = 41, R_CPRE = 42, R_GPIO4 = 43;
  localparam int R_FCRH = 44, R_FCRL = 45, R_SLEEP = 46, R_OPT = 47, R_FSMODE = 48;
  localparam int R_FSWH = 49, R_FSWL = 50, R_FSD2 = 51, R_FSD1 = 52, R_FSD0 = 53;
  localparam int R_SKP = 54, R_SKI = 55;

  localparam logic [15:0] CSIT_OFFS [CSIT_NREG] = '{
    16'h4800, 16'h4802, 16'h4803, 16'h4805, 16'h4806, 16'h4807, 16'h4808, 16'h4810,
    16'h4811, 16'h4813, 16'h4814, 16'h4818, 16'h4819, 16'h481a, 16'h481b, 16'h481c,
    16'h481d, 16'h481e, 16'h481f, 16'h4820, 16'h4821, 16'h4822, 16'h4823, 16'h4824,
    16'h4825, 16'h4826, 16'h4827, 16'h4828, 16'h4829, 16'h482a, 16'h482b, 16'h482c,
    16'h482d, 16'h482e, 16'h482f, 16'h4830, 16'h4831, 16'h4832, 16'h4833, 16'h4837,
    16'h4838, 16'h4839, 16'h483c, 16'h483d, 16'h483e, 16'h483f, 16'h484a, 16'h484b,
    16'h4310, 16'h4311, 16'h4312, 16'h4314, 16'h4315, 16'h4316, 16'h4852, 16'h4853};

  localparam logic [7:0] CSIT_RST [CSIT_NREG] = '{
    8'h04, 8'h00, 8'h30, 8'h00, 8'h00, 8'h03, 8'h18, 8'hff,
    8'hff, 8'h00, 8'h2a, 8'h00, 8'h70, 8'h00, 8'h3c, 8'h01,
    8'h2c, 8'h5f, 8'h26, 8'h00, 8'h3c, 8'h00, 8'h3c, 8'h00,
    8'h32, 8'h32, 8'h55, 8'h00, 8'h64, 8'h06, 8'h04, 8'h00,
    8'h00, 8'h34, 8'h00, 8'h00, 8'h64, 8'h00, 8'h10, 8'h14,
    8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h3f, 8'h03,
    8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // Field positions
  localparam int B_FORCE_HS = 7, B_GATING = 5, B_LINE_PKT = 4, B_FIRST_BIT = 1, B_LPX_SEL = 0;
  localparam int B_LSB_FIRST = 0, B_DT_SEL = 6, B_DT_MSB = 5, B_VC_MSB = 1, B_FS_EOF = 0;
  localparam int B_NIB_SEL = 3, B_NIB_DIR = 2, B_NIB_P = 1, B_NIB_N = 0, B_NIB_W = 4;
  localparam int B_SLP_MAN = 2, B_SLP_CK = 1, B_SLP_DA = 0, B_CPRE_MSB = 3;
  localparam int B_SAME_SKEW = 3, B_LINE_ST = 2, B_CLK_ST = 1, B_SOF_SEL = 0;
  localparam int B_NS_HI_MSB = 1, B_UI_MSB = 5, B_UI_NIB_MSB = 3;

  localparam logic [5:0] CSIT_DT_EMBED = 6'h12;
  localparam logic [7:0] CSIT_CLK_PAT0 = 8'h55;
  localparam logic [7:0] CSIT_CLK_PAT1 = 8'haa;
  localparam logic [31:0] CSIT_PS_PER_NS = 32'd1000;
  localparam logic [31:0] CSIT_PS_PER_HALF_NS = 32'd500;
  localparam logic [7:0] CSIT_CYC_MAX = 8'hff;
  localparam logic [3:0] CSIT_LP_BITS = 4'h8;

  // Timing order: 0 clk_zero, 1 hs_trail, 2 hs_zero, 3 hs_exit, 4 clk_trail,
  // 5 clk_post, 6 clk_prepare, 7 hs_prepare, 8 lpx
  localparam int CSIT_TIM_NSH [CSIT_NTIM] = '{R_CZH, R_HTH, R_HZH, R_HEH, R_CTH, R_CPOH,
                                              -1, -1, R_LXH};
  localparam int CSIT_TIM_NSL [CSIT_NTIM] = '{R_CZL, R_HTL, R_HZL, R_HEL, R_CTL, R_CPOL,
                                              R_CPMIN, R_HPMIN, R_LXL};
  localparam int CSIT_TIM_UI [CSIT_NTIM] = '{R_UCZ, R_UHT, R_UHZ, R_UHE, R_UCT, R_UCPO,
                                             R_UCP, R_UHP, R_ULX};
  localparam logic [9:0] CSIT_AUTO_NS [CSIT_NTIM] = '{10'h12c, 10'h03c, 10'h070, 10'h064,
                                                      10'h03c, 10'h03c, 10'h026, 10'h032,
                                                      10'h032};
  localparam logic [5:0] CSIT_AUTO_UI [CSIT_NTIM] = '{6'h00, 6'h04, 6'h06, 6'h00, 6'h00,
                                                      6'h34, 6'h00, 6'h04, 6'h00};

  typedef struct packed {
    logic sof;
    logic eof;
    logic line_valid;
    logic fifo_start;
    logic embedded;
  } csit_frame_ev_t;

  typedef struct packed {
    logic oe;
    logic p;
    logic n;
  } csit_lp_pin_t;

  typedef struct packed {
    logic [CSIT_NTIM-1:0][7:0] cycles;
    logic [3:0]                clk_pre;
  } csit_phy_timing_t;

  typedef enum logic [1:0] {
    FS_IDLE  = 2'b00,
    FS_DELAY = 2'b01,
    FS_PULSE = 2'b11
  } csit_fs_state_t;

  // Storage index of a register offset, CSIT_NREG when unmapped
  function automatic int csit_find(input logic [15:0] offs);
    int hit;
    hit = CSIT_NREG;
    for (int i = 0; i < CSIT_NREG; i++)
    begin
      if (CSIT_OFFS[i] == offs)
      begin
        hit = i;
      end
    end
    return hit;
  endfunction

endpackage

// ==== logic/csit_cycles.sv ====
/*
  Converts a physical-layer time of ns plus UI terms into whole pclk2x cycles.
  Assumes the period input holds half-nanosecond units; purely combinational.
*/
module csit_cycles
  #(parameter int UI_PS = 1250)
  (
    input  wire logic [9:0] ns,
    input  wire logic [5:0] ui,
    input  wire logic [7:0] period,
    output logic      [7:0] cycles
  );
  import csit_pkg::*;

  logic [31:0] need_ps;
  logic [31:0] per_ps;
  logic [31:0] quo;

  always_comb
  begin
    need_ps = 32'(ns) * CSIT_PS_PER_NS + 32'(ui) * 32'(UI_PS);
    per_ps  = (period == '0) ? CSIT_PS_PER_HALF_NS : 32'(period) * CSIT_PS_PER_HALF_NS;
    quo     = (need_ps + per_ps - 32'd1) / per_ps;
    cycles  = (quo > 32'(CSIT_CYC_MAX)) ? CSIT_CYC_MAX : quo[7:0];
  end

endmodule

// ==== logic/csit_top.sv ====
/*
  CSI transmit control: frame sync pulse, physical-layer timing selection,
  packet options, low-power lane overrides, sleep states and start sequencing.
  Assumes an AHB-Lite master, same-clock frame events and an asynchronous link clock.
*/
module csit_top
  #(parameter int UI_PS = 1250)
  (
    input  wire logic                               ref_clk,
    input  wire logic                               rst_n,
    input  wire logic                               hsel,
    input  wire logic [31:0]                        haddr,
    input  wire logic [1:0]                         htrans,
    input  wire logic                               hwrite,
    input  wire logic [2:0]                         hsize,
    input  wire logic [31:0]                        hwdata,
    input  wire logic                               hready,
    output logic                                    hreadyout,
    output logic                                    hresp,
    output logic [31:0]                             hrdata,
    input  wire csit_pkg::csit_frame_ev_t           frame_ev,
    input  wire logic [5:0]                         pixel_data_type,
    input  wire logic                               packet_pending,
    input  wire logic                               sleep_mode,
    input  wire logic                               link_clk,
    input  wire logic [7:0]                         lp_tx_byte,
    input  wire logic                               lp_tx_valid,
    output logic                                    lp_tx_ready,
    output logic                                    lp_tx_active,
    output logic                                    frame_sync,
    output logic                                    frame_start,
    output logic                                    line_start,
    output logic [15:0]                             frame_number,
    output logic                                    hs_mode,
    output logic                                    clock_lane_run,
    output logic                                    line_packet_en,
    output logic [7:0]                              clk_lane_byte,
    output logic [5:0]                              data_type,
    output logic [1:0]                              virtual_channel,
    output csit_pkg::csit_phy_timing_t              phy_timing,
    output logic [7:0]                              skew_init_dur,
    output logic [7:0]                              skew_periodic_dur,
    output csit_pkg::csit_lp_pin_t [csit_pkg::CSIT_NLANE-1:0] lane_lp
  );
  import csit_pkg::*;

  logic [7:0]           regs [CSIT_NREG];
  logic                 wr_pend;
  logic                 rd_pend;
  int                   ph_idx;
  logic                 ap_valid;
  logic [15:0]          fcnt;
  csit_fs_state_t       fs_state;
  csit_fs_state_t       next_fs_state;
  logic [23:0]          fs_cnt;
  logic [23:0]          next_fs_cnt;
  logic                 fs_trig;
  logic                 lv_q;
  logic                 lv_rise;
  logic                 fs_armed;
  logic                 next_frame_start;
  logic                 clk_started;
  logic                 lk_s1;
  logic                 lk_s2;
  logic                 lk_s3;
  logic                 lk_edge;
  logic [7:0]           lp_sh;
  logic [3:0]           lp_cnt;
  logic                 lp_lsb;
  logic                 lp_bit;
  logic [9:0]           tim_ns [CSIT_NTIM];
  logic [5:0]           tim_ui [CSIT_NTIM];
  logic [7:0]           tim_cyc [CSIT_NTIM];

  function automatic logic [7:0] read_byte(input int idx, input logic [15:0] cnt);
    logic [7:0] val;
    val = '0;
    if (idx == R_FCRH)
    begin
      val = cnt[15:8];
    end
    else if (idx == R_FCRL)
    begin
      val = cnt[7:0];
    end
    else if (idx < CSIT_NREG)
    begin
      val = regs[idx];
    end
    return val;
  endfunction

  // Bus slave: writes take no wait, reads take one wait state
  assign ap_valid  = hsel & htrans[1] & hready;
  assign hreadyout = ~rd_pend;
  assign hresp     = 1'b0;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      ph_idx  <= CSIT_NREG;
    end
    else
    begin
      wr_pend <= ap_valid & hwrite;
      rd_pend <= ap_valid & ~hwrite;
      if (ap_valid)
      begin
        ph_idx <= (haddr[1:0] == '0 && haddr[31:CSIT_ADDR_TOP] == '0)
                  ? csit_find(haddr[CSIT_ADDR_TOP-1:2]) : CSIT_NREG;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      hrdata <= '0;
    end
    else if (rd_pend)
    begin
      hrdata <= 32'(read_byte(ph_idx, fcnt));
    end
  end

  // Register storage; readback registers ignore writes
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < CSIT_NREG; i++)
      begin
        regs[i] <= CSIT_RST[i];
      end
    end
    else if (wr_pend && ph_idx < CSIT_NREG && ph_idx != R_FCRH && ph_idx != R_FCRL)
    begin
      regs[ph_idx] <= hwdata[7:0];
    end
  end

  // Frame sync pulse generator
  assign fs_trig = regs[R_FSMODE][B_FS_EOF] ? frame_ev.eof : frame_ev.sof;

  always_comb
  begin
    next_fs_state = fs_state;
    next_fs_cnt   = fs_cnt;
    unique case (fs_state)
      FS_IDLE:
      begin
        if (fs_trig)
        begin
          if ({regs[R_FSD2], regs[R_FSD1], regs[R_FSD0]} == '0)
          begin
            next_fs_state = FS_PULSE;
            next_fs_cnt   = 24'({regs[R_FSWH], regs[R_FSWL]}) - 24'd1;
          end
          else
          begin
            next_fs_state = FS_DELAY;
            next_fs_cnt   = {regs[R_FSD2], regs[R_FSD1], regs[R_FSD0]} - 24'd1;
          end
        end
      end
      FS_DELAY:
      begin
        if (fs_cnt == '0)
        begin
          next_fs_state = FS_PULSE;
          next_fs_cnt   = 24'({regs[R_FSWH], regs[R_FSWL]}) - 24'd1;
        end
        else
        begin
          next_fs_cnt = fs_cnt - 24'd1;
        end
      end
      FS_PULSE:
      begin
        if (fs_cnt == '0 || fs_cnt[23])
        begin
          next_fs_state = FS_IDLE;
          next_fs_cnt   = '0;
        end
        else
        begin
          next_fs_cnt = fs_cnt - 24'd1;
        end
      end
      default:
      begin
        next_fs_state = FS_IDLE;
        next_fs_cnt   = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      fs_state   <= FS_IDLE;
      fs_cnt     <= '0;
      frame_sync <= 1'b0;
    end
    else
    begin
      fs_state   <= next_fs_state;
      fs_cnt     <= next_fs_cnt;
      frame_sync <= (next_fs_state == FS_PULSE);
    end
  end

  // Frame and line start sequencing
  assign lv_rise = frame_ev.line_valid & ~lv_q;
  assign next_frame_start = regs[R_OPT][B_SOF_SEL] ? frame_ev.sof : (lv_rise & fs_armed);

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      lv_q        <= 1'b0;
      fs_armed    <= 1'b0;
      frame_start <= 1'b0;
      line_start  <= 1'b0;
    end
    else
    begin
      lv_q        <= frame_ev.line_valid;
      fs_armed    <= frame_ev.sof | (fs_armed & ~lv_rise);
      frame_start <= next_frame_start;
      line_start  <= regs[R_OPT][B_LINE_ST] ? frame_ev.fifo_start : lv_rise;
    end
  end

  // Frame number wraps from the programmed maximum back to one
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      fcnt <= '0;
    end
    else if (next_frame_start)
    begin
      fcnt <= (fcnt >= {regs[R_FMAXH], regs[R_FMAXL]}) ? 16'h0001 : fcnt + 16'h0001;
    end
  end

  assign frame_number = fcnt;

  // Lane mode, clock lane and packet options
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      clk_started     <= 1'b0;
      hs_mode         <= 1'b0;
      clock_lane_run  <= 1'b0;
      line_packet_en  <= 1'b0;
      clk_lane_byte   <= CSIT_CLK_PAT0;
      data_type       <= '0;
      virtual_channel <= '0;
    end
    else
    begin
      clk_started    <= clk_started | regs[R_OPT][B_CLK_ST] | frame_ev.sof;
      hs_mode        <= regs[R_MAIN][B_FORCE_HS] | packet_pending;
      clock_lane_run <= clk_started & (~regs[R_MAIN][B_GATING] | packet_pending
                        | regs[R_MAIN][B_FORCE_HS]);
      line_packet_en <= regs[R_MAIN][B_LINE_PKT];
      clk_lane_byte  <= regs[R_MAIN][B_FIRST_BIT] ? CSIT_CLK_PAT1 : CSIT_CLK_PAT0;
      if (regs[R_DT][B_DT_SEL])
      begin
        data_type <= regs[R_DT][B_DT_MSB:0];
      end
      else
      begin
        data_type <= frame_ev.embedded ? CSIT_DT_EMBED : pixel_data_type;
      end
      virtual_channel <= regs[R_VC][B_VC_MSB:0];
    end
  end

  // Physical-layer timings, automatic or programmed per select bit
  genvar t;
  generate
    for (t = 0; t < CSIT_NTIM; t++)
    begin : g_tim
      logic man;
      logic [9:0] ns_prog;
      logic [5:0] ui_prog;
      if (t == CSIT_NTIM - 1)
      begin : g_lpx
        assign man = regs[R_MAIN][B_LPX_SEL];
      end
      else
      begin : g_sel
        assign man = regs[R_TSEL][t];
      end
      if (CSIT_TIM_NSH[t] < 0)
      begin : g_short
        assign ns_prog = 10'(regs[CSIT_TIM_NSL[t]]);
        assign ui_prog = 6'(regs[CSIT_TIM_UI[t]][B_UI_NIB_MSB:0]);
      end
      else
      begin : g_long
        assign ns_prog = {regs[CSIT_TIM_NSH[t]][B_NS_HI_MSB:0], regs[CSIT_TIM_NSL[t]]};
        assign ui_prog = regs[CSIT_TIM_UI[t]][B_UI_MSB:0];
      end
      assign tim_ns[t] = man ? ns_prog : CSIT_AUTO_NS[t];
      assign tim_ui[t] = man ? ui_prog : CSIT_AUTO_UI[t];
      csit_cycles #(.UI_PS(UI_PS)) u_cyc
      (
        .ns     (tim_ns[t]),
        .ui     (tim_ui[t]),
        .period (regs[R_PER]),
        .cycles (tim_cyc[t])
      );
      always_ff @(posedge ref_clk)
      begin
        if (!rst_n)
        begin
          phy_timing.cycles[t] <= '0;
        end
        else
        begin
          phy_timing.cycles[t] <= tim_cyc[t];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      phy_timing.clk_pre <= '0;
      skew_init_dur      <= '0;
      skew_periodic_dur  <= '0;
    end
    else
    begin
      phy_timing.clk_pre <= regs[R_CPRE][B_CPRE_MSB:0];
      skew_init_dur      <= regs[R_SKI];
      skew_periodic_dur  <= regs[R_OPT][B_SAME_SKEW] ? regs[R_SKI] : regs[R_SKP];
    end
  end

  // Link clock synchroniser and low-power byte serialiser
  assign lk_edge     = lk_s2 & ~lk_s3;
  assign lp_tx_ready = ~lp_tx_active;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      lk_s1        <= 1'b0;
      lk_s2        <= 1'b0;
      lk_s3        <= 1'b0;
      lp_tx_active <= 1'b0;
      lp_sh        <= '0;
      lp_cnt       <= '0;
      lp_lsb       <= 1'b0;
      lp_bit       <= 1'b0;
    end
    else
    begin
      lk_s1 <= link_clk;
      lk_s2 <= lk_s1;
      lk_s3 <= lk_s2;
      if (lp_tx_valid && !lp_tx_active)
      begin
        lp_tx_active <= 1'b1;
        lp_sh        <= lp_tx_byte;
        lp_cnt       <= '0;
        lp_lsb       <= regs[R_PWR][B_LSB_FIRST];
      end
      else if (lp_tx_active && lk_edge)
      begin
        if (lp_cnt == CSIT_LP_BITS)
        begin
          lp_tx_active <= 1'b0;
        end
        else
        begin
          lp_bit <= lp_lsb ? lp_sh[0] : lp_sh[7];
          lp_sh  <= lp_lsb ? {1'b0, lp_sh[7:1]} : {lp_sh[6:0], 1'b0};
          lp_cnt <= lp_cnt + 4'h1;
        end
      end
    end
  end

  // Low-power pins: lanes 0 to 3 are data, lane 4 is the clock lane
  genvar l;
  generate
    for (l = 0; l < CSIT_NLANE; l++)
    begin : g_lane
      logic [B_NIB_W-1:0] nib;
      logic               in_hs;
      logic               stop_lvl;
      logic               auto_p;
      logic               auto_n;
      if (l == CSIT_NLANE - 1)
      begin : g_ck
        assign nib      = regs[R_GPIO4][2*B_NIB_W-1:B_NIB_W];
        assign in_hs    = clock_lane_run;
        assign stop_lvl = ~(sleep_mode & regs[R_SLEEP][B_SLP_MAN]) | regs[R_SLEEP][B_SLP_CK];
      end
      else
      begin : g_da
        assign nib      = regs[R_GPIO0 + l / 2][(2 - l % 2) * B_NIB_W - 1 -: B_NIB_W];
        assign in_hs    = hs_mode;
        assign stop_lvl = ~(sleep_mode & regs[R_SLEEP][B_SLP_MAN]) | regs[R_SLEEP][B_SLP_DA];
      end
      assign auto_p = (l == 0 && lp_tx_active) ? lp_bit : stop_lvl;
      assign auto_n = (l == 0 && lp_tx_active) ? ~lp_bit : stop_lvl;
      always_ff @(posedge ref_clk)
      begin
        if (!rst_n)
        begin
          lane_lp[l] <= '0;
        end
        else if (nib[B_NIB_SEL])
        begin
          lane_lp[l] <= '{oe: nib[B_NIB_DIR], p: nib[B_NIB_P], n: nib[B_NIB_N]};
        end
        else
        begin
          lane_lp[l] <= '{oe: ~in_hs, p: auto_p & ~in_hs, n: auto_n & ~in_hs};
        end
      end
    end
  endgenerate

endmodule

// ==== tb/csit_properties.sv ====
/* Port checker of csit_top.
   Bound to csit_top; sees its ports only, one clock domain. */
module csit_properties
  (
    input wire logic                     ref_clk,
    input wire logic                     rst_n,
    input wire csit_pkg::csit_frame_ev_t frame_ev,
    input wire logic                     frame_start,
    input wire logic                     line_start,
    input wire logic [15:0]              frame_number,
    input wire logic                     frame_sync,
    input wire logic                     lp_tx_valid,
    input wire logic                     lp_tx_ready,
    input wire logic                     lp_tx_active,
    input wire logic [7:0]               clk_lane_byte
  );
  timeunit 1ns;
  timeprecision 1ps;
  import csit_pkg::*;
  logic trig_seen;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Any trigger seen since reset
  always_ff @(posedge ref_clk)
  begin
    trig_seen <= rst_n & (trig_seen | frame_ev.sof | frame_ev.eof);
  end
  property p_pat; clk_lane_byte == 8'h55 || clk_lane_byte == 8'haa; endproperty
  a_pat: assert property (p_pat) else $error("bad clock pattern");
  property p_fn_src; $changed(frame_number) |-> frame_start; endproperty
  a_fn_src: assert property (p_fn_src) else $error("frame number moved");
  property p_fn_nz; frame_start |-> frame_number != 16'h0; endproperty
  a_fn_nz: assert property (p_fn_nz) else $error("frame number zero");
  property p_fst; frame_start |-> $past(frame_ev.sof) || $past(frame_ev.line_valid); endproperty
  a_fst: assert property (p_fst) else $error("frame start cause");
  property p_lst; line_start |-> $past(frame_ev.line_valid) || $past(frame_ev.fifo_start);
  endproperty
  a_lst: assert property (p_lst) else $error("line start cause");
  property p_take; lp_tx_valid && lp_tx_ready |=> lp_tx_active; endproperty
  a_take: assert property (p_take) else $error("byte not taken");
  property p_rdy; $fell(lp_tx_active) |-> $past(lp_tx_active, 8); endproperty
  a_rdy: assert property (p_rdy) else $error("byte ended early");
  property p_fs_src; $rose(frame_sync) |-> trig_seen; endproperty
  a_fs_src: assert property (p_fs_src) else $error("sync without trigger");
  c_fs: cover property ($rose(frame_sync));
  c_lp: cover property ($fell(lp_tx_active));
  c_ls: cover property (line_start);
endmodule

bind csit_top csit_properties u_props (.ref_clk, .rst_n, .frame_ev, .frame_start, .line_start,
  .frame_number, .frame_sync, .lp_tx_valid, .lp_tx_ready, .lp_tx_active, .clk_lane_byte);

// ==== tb/csit_rx_model.sv ====
/* Far-end model: runs the link clock for one byte, samples data lane 0.
   Assumes go rises once per low-power byte. */
module csit_rx_model
  (
    input wire logic  go,
    input wire logic  lane_p,
    output logic      link_clk,
    output logic [7:0] got
  );
  timeunit 1ns;
  timeprecision 1ps;
  initial link_clk = 1'b0;
  initial got = 8'h00;
  // Nine edges per byte, clock still between bytes
  always @(posedge go)
  begin
    repeat (9)
    begin
      #167 link_clk = 1'b1;
      got = {got[6:0], lane_p};
      #153 link_clk = 1'b0;
    end
  end
endmodule

// ==== tb/testbench.sv ====
/* Self-checking bench of csit_top over AHB-Lite, frame events and low power.
   Assumes csit_rx_model at the far end and the bound checker. */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import csit_pkg::*;
  logic ref_clk, hreadyout, hresp, link_clk, lp_tx_ready, lp_tx_active, frame_sync;
  logic frame_start, line_start, hs_mode, clock_lane_run, line_packet_en;
  logic rst_n = 0, hsel = 1, hwrite = 0, lp_tx_valid = 0, go = 0, packet_pending = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q_rd[$], q_fs[$], q_lp[$];
  logic [1:0] htrans = 0, virtual_channel;
  logic [7:0] lp_tx_byte = 0, got, clk_lane_byte, skew_init_dur, skew_periodic_dur, r;
  logic [5:0] pixel_data_type = 0, data_type;
  logic [15:0] frame_number;
  csit_frame_ev_t frame_ev = '0;
  csit_phy_timing_t phy_timing;
  csit_lp_pin_t [CSIT_NLANE-1:0] lane_lp;
  logic rd_ph = 0, fs_q = 0, lp_q = 0, sleep_mode = 0;
  int fail_count = 0, checks_done = 0, c = 0, w = 0, d;
  logic [15:0] ra[7] = '{16'h4800, 16'h4810, 16'h4814, 16'h483c, 16'h484b, 16'h483e, 16'h4801};
  logic [7:0] re[7] = '{8'h04, 8'hff, 8'h2a, 8'h02, 8'h03, 8'h00, 8'h00};
  csit_top dut (.ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .frame_ev, .pixel_data_type,
    .packet_pending, .sleep_mode, .link_clk, .lp_tx_byte, .lp_tx_valid, .lp_tx_ready,
    .lp_tx_active, .frame_sync, .frame_start, .line_start, .frame_number, .hs_mode,
    .clock_lane_run, .line_packet_en, .clk_lane_byte, .data_type, .virtual_channel,
    .phy_timing, .skew_init_dur, .skew_periodic_dur, .lane_lp);
  csit_rx_model far_end (.go, .lane_p(lane_lp[0].p), .link_clk, .got);
  initial
  begin
    ref_clk = 0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic chk(input string s, input logic [31:0] v, input logic [31:0] e);
    checks_done++;
    if (v !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [31:0] pop(ref logic [31:0] q[$]);
    if (q.size() == 0)
      return 'x;
    return q.pop_front();
  endfunction
  task automatic wt;
    int n = 0;
    do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++n < 99);
    if (n >= 99)
    begin
      fail_count++;
      stop_test();
    end
  endtask
  task automatic bus(input logic wr_en, input logic [15:0] a, input logic [7:0] v);
    haddr <= {14'h0, a, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr_en;
    wt();
    htrans <= 2'h0;
    hwdata <= {24'h0, v};
    wt();
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    bus(1'b1, a, v);
  endtask
  task automatic ev(input int i);
    frame_ev <= csit_frame_ev_t'(5'h10 >> i);
    @(posedge ref_clk);
    frame_ev <= '0;
    repeat (40) @(posedge ref_clk);
  endtask
  task automatic lp(input logic lsb);
    r = 8'($urandom);
    lp_tx_byte <= r;
    if (lsb)
      r = {<<{r}};
    q_lp.push_back({24'h0, r});
    lp_tx_valid <= 1'b1;
    go <= 1'b1;
    @(posedge ref_clk);
    lp_tx_valid <= 1'b0;
    go <= 1'b0;
    repeat (100) @(posedge ref_clk);
  endtask
  // Result watcher: reads, sync pulses, low-power bytes
  always @(posedge ref_clk)
  begin
    if (rd_ph && hreadyout === 1'b1)
    begin
      chk("read data", hrdata, pop(q_rd));
      rd_ph = 0;
    end
    if (hsel && htrans[1] && hreadyout && !hwrite)
      rd_ph = 1;
    c = (frame_ev.sof || frame_ev.eof) ? 0 : c + 1;
    if (frame_sync && !fs_q)
      chk("sync delay", c, pop(q_fs));
    if (!frame_sync && fs_q)
      chk("sync width", w, pop(q_fs));
    w = frame_sync ? w + 1 : 0;
    fs_q = frame_sync;
    if (lp_q && lp_tx_active === 1'b0)
      chk("lp byte", got, pop(q_lp));
    lp_q = lp_tx_active;
  end
  initial
  begin
    void'($urandom(32'h06630ca6));
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    wr(16'h483e, 8'h55);
    for (int i = 0; i < 7; i++)
    begin
      q_rd.push_back({24'h0, re[i]});
      bus(1'b0, ra[i], 8'h00);
    end
    wr(16'h4810, 8'h00);
    wr(16'h4811, 8'h02);
    for (int i = 0; i < 3; i++)
    begin
      q_fs.push_back(1);
      q_fs.push_back(16);
      ev(0);
      chk("frame number", frame_number, i % 2 + 1);
    end
    d = $urandom_range(9);
    wr(16'h4316, 8'(d));
    wr(16'h4312, 8'(d + 1));
    wr(16'h4310, 8'h01);
    ev(0);
    q_fs.push_back(d + 1);
    q_fs.push_back(d + 1);
    ev(1);
    ev(2);
    r = 8'($urandom);
    wr(16'h4837, 8'h28);
    wr(16'h4802, 8'h04);
    wr(16'h4819, r);
    wr(16'h4825, 8'h64);
    wr(16'h4800, 8'h93);
    wr(16'h4814, {2'h1, r[5:0]});
    repeat (3) @(posedge ref_clk);
    chk("hs mode", hs_mode, 1);
    chk("line packets", line_packet_en, 1);
    chk("clock pattern", clk_lane_byte, 8'haa);
    chk("lpx", phy_timing.cycles[8], 5);
    chk("hs zero", phy_timing.cycles[2], (r * 1000 + 27499) / 20000);
    chk("clk zero", phy_timing.cycles[0], 15);
    chk("manual type", data_type, r[5:0]);
    pixel_data_type <= ~r[5:0];
    wr(16'h4814, 8'h2a);
    repeat (3) @(posedge ref_clk);
    chk("derived type", data_type, pixel_data_type);
    frame_ev <= 5'h01;
    repeat (3) @(posedge ref_clk);
    chk("embedded type", data_type, 6'h12);
    frame_ev <= '0;
    wr(16'h4838, 8'he0);
    wr(16'h483d, 8'h90);
    wr(16'h4853, 8'h05);
    wr(16'h4852, 8'h09);
    wr(16'h4800, 8'h20);
    repeat (3) @(posedge ref_clk);
    chk("data lane", lane_lp[0], 3'b110);
    chk("clock lane", lane_lp[4], 3'b001);
    chk("skew init", skew_init_dur, 5);
    chk("skew periodic", skew_periodic_dur, 9);
    chk("clock pre", phy_timing.clk_pre, 2);
    chk("clock gated", clock_lane_run, 0);
    packet_pending <= 1'b1;
    wr(16'h484b, 8'h0b);
    wr(16'h4838, 8'h00);
    repeat (3) @(posedge ref_clk);
    chk("skew shared", skew_periodic_dur, 5);
    chk("clock running", clock_lane_run, 1);
    packet_pending <= 1'b0;
    lp(1'b0);
    wr(16'h4806, 8'h01);
    lp(1'b1);
    sleep_mode <= 1'b1;
    wr(16'h484a, 8'h04);
    repeat (3) @(posedge ref_clk);
    chk("sleep lanes", lane_lp[1], 3'b100);
    wr(16'h484b, 8'h04);
    ev(0);
    ev(2);
    chk("line frame", frame_number, 1);
    stop_test();
  end
endmodule
